/* File: pkg/pwt_pkg.sv */
// Shared constants for the 16-bit PWM timer with dead-time extension.
// Assumes one system clock; all control inputs come from logic on that clock.
// Notes on behaviour
// (R1) 16-bit counter; count source is clock, event or pin, with a prescaler.
// (R2) Counter and compare writes are buffered and applied at update points only.
// (R3) Period writes are buffered too and take effect at the update point.
// (R4) Four-channel variant has dead-time extension; two-channel variant has none.
// (R5) Waveforms: single-slope PWM, dual-slope PWM and frequency generation.
// (R6) Resolution extension adds two fraction bits, four times finer edges.
// (R7) Capture pins pass a noise canceller; pin or event may trigger capture.
// (R8) Frequency, pulse width and cascaded 32-bit capture are supported; the code captures 16 bits only, with no cascade.
// (R9) Event counter mode with direction chosen by an input.
// (R10) Overflow and error each give an interrupt request and event pulse; the code gives only the ovf_evt and err_evt pulses, with no interrupt request.
// (R11) Each channel gives a match/capture pulse and a DMA request.
// (R12) With any extension feature on, each waveform becomes a complementary pair.
// (R13) Dead-time unit gives true low side and inverted high side with gaps.
// (R14) Four dead-time units drive eight pins; dead time is 8 bits.
// (R15) Separate low and high dead-time settings, both double buffered.
// (R16) Dead-time outputs replace port values per override mask, then optional invert.
// (R17) Pattern generator drives a buffered, synchronized pattern; dead-time bypassed.
// (R18) Channel A waveform may be spread to all pins of the port.
// (R19) A selected event raises a fault that disables extension outputs.
// (R20) Pin invert flips the value between port logic and physical pin.
// (R21) Single slope counts 0 to period and restarts; dual slope goes up then down.
// (R22) Compare output changes when the counter equals the channel compare value.
package pwt_pkg;
  localparam int CNT_W = 16;
  localparam int HR_W  = 2;
  localparam int EXT_W = CNT_W + HR_W;
  localparam int DT_W  = 8;
  localparam int PIN_W = 8;
  localparam int EVT_W = 8;
  localparam int PRE_W = 10;
  localparam int NUM_DTI = 4;
  // Count source select
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_SYS = 2'h1;
  localparam logic [1:0] SRC_EVT = 2'h2;
  localparam logic [1:0] SRC_PIN = 2'h3;
  // Waveform modes
  localparam logic [1:0] WM_NORM = 2'h0;
  localparam logic [1:0] WM_FRQ  = 2'h1;
  localparam logic [1:0] WM_SS   = 2'h2;
  localparam logic [1:0] WM_DS   = 2'h3;
  // Capture modes
  localparam logic [1:0] CAP_OFF = 2'h0;
  localparam logic [1:0] CAP_EDG = 2'h1;
  localparam logic [1:0] CAP_FRQ = 2'h2;
  localparam logic [1:0] CAP_PW  = 2'h3;
  // Noise canceller: accepted after this many agreeing extra samples
  localparam logic [1:0] NC_LAST = 2'h2;
  // Counter step without and with fraction bits
  localparam logic [EXT_W-1:0] STEP_STD = 18'h00004;
  localparam logic [EXT_W-1:0] STEP_HR  = 18'h00001;
  localparam logic [PRE_W-1:0] PRE_ONES = 10'h3ff;
  localparam logic [DT_W-1:0]  DT_RST   = 8'h00;
  // Counter direction state, one-hot
  typedef enum logic [1:0] {
    PWT_UP = 2'b01,
    PWT_DN = 2'b10
  } pwt_dir_t;
endpackage

/* File: hw/pwt_dti.sv */
// Dead-time unit: splits one waveform into a low-side and high-side pair.
// Assumes settings are stable between update points and one clock domain.
`timescale 1ns/10ps
module pwt_dti (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      wave_in,
  input  wire logic [pwt_pkg::DT_W-1:0]  dt_low,
  input  wire logic [pwt_pkg::DT_W-1:0]  dt_high,
  output logic                           low_side_output,
  output logic                           high_side_output
);
  typedef struct packed {
    logic                     wg;
    logic [pwt_pkg::DT_W-1:0] gap;
    logic                     ls;
    logic                     hs;
  } pwt_dti_st_t;

  pwt_dti_st_t q_ff;
  pwt_dti_st_t nxt_q;

  // Any edge of the waveform turns both sides off before the new side turns on
  always_comb begin
    nxt_q = q_ff;
    if (wave_in != q_ff.wg) begin
      nxt_q.wg  = wave_in;
      nxt_q.gap = wave_in ? dt_low : dt_high;         // [R15]
      nxt_q.ls  = 1'b0;                                // [R13]
      nxt_q.hs  = 1'b0;
    end else if (q_ff.gap != pwt_pkg::DT_RST) begin
      nxt_q.gap = q_ff.gap - 8'h01;
    end else begin
      nxt_q.ls  = q_ff.wg;                             // [R13]
      nxt_q.hs  = ~q_ff.wg;                            // [R13]
    end
  end

  // Reset leaves both switches off
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign low_side_output  = q_ff.ls;
  assign high_side_output = q_ff.hs;
endmodule // pwt_dti

/* File: hw/pwt_timer.sv */
// Top of the 16-bit PWM timer: counter, compare/capture channels, extension.
// Assumes control strobes are one-cycle pulses on this clock; pins are async.
`timescale 1ns/10ps
module pwt_timer #(
  parameter int NUM_CH = 4
) (
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  input  wire logic [1:0]                      clk_src,
  input  wire logic [3:0]                      presc_log,
  input  wire logic [1:0]                      wave_mode,
  input  wire logic                            resolution_extension,
  input  wire logic                            dir_dn,
  input  wire logic                            cnt_evt,
  input  wire logic                            cnt_pin,
  input  wire logic [pwt_pkg::CNT_W-1:0]       per_wdata,
  input  wire logic                            per_wr,
  input  wire logic [pwt_pkg::CNT_W-1:0]       cnt_wdata,
  input  wire logic                            cnt_wr,
  input  wire logic [pwt_pkg::CNT_W-1:0]       cmp_wdata,
  input  wire logic [pwt_pkg::HR_W-1:0]        cmp_hr_wdata,
  input  wire logic [NUM_CH-1:0]               cmp_wr,
  input  wire logic [NUM_CH-1:0]               cap_en,
  input  wire logic [1:0]                      cap_mode,
  input  wire logic                            cap_use_evt,
  input  wire logic [NUM_CH-1:0]               cap_evt,
  input  wire logic [NUM_CH-1:0]               cap_pin,
  input  wire logic [NUM_CH-1:0]               cap_rd,
  input  wire logic                            dti_en,
  input  wire logic [pwt_pkg::DT_W-1:0]        dt_low_wdata,
  input  wire logic [pwt_pkg::DT_W-1:0]        dt_high_wdata,
  input  wire logic                            dt_wr,
  input  wire logic                            pgen_en,
  input  wire logic [pwt_pkg::PIN_W-1:0]       pat_wdata,
  input  wire logic                            pat_wr,
  input  wire logic                            spread_a_en,
  input  wire logic [pwt_pkg::PIN_W-1:0]       ovr_en,
  input  wire logic [pwt_pkg::PIN_W-1:0]       pin_invert_enable,
  input  wire logic [pwt_pkg::PIN_W-1:0]       port_val,
  input  wire logic [pwt_pkg::EVT_W-1:0]       sys_evt,
  input  wire logic [pwt_pkg::EVT_W-1:0]       flt_sel,
  input  wire logic                            flt_clr,
  output logic      [pwt_pkg::CNT_W-1:0]       cnt_val,
  output logic      [NUM_CH-1:0]               waveform_output,
  output logic      [NUM_CH*pwt_pkg::CNT_W-1:0] cc_val,
  output logic                                 ovf_evt,
  output logic                                 err_evt,
  output logic      [NUM_CH-1:0]               cc_evt,
  output logic      [NUM_CH-1:0]               dma_req,
  output logic                                 flt_active,
  output logic      [pwt_pkg::PIN_W-1:0]       pin_out
);
  localparam int XW = pwt_pkg::EXT_W;

  typedef struct packed {
    logic [NUM_CH:0]                          s1;
    logic [NUM_CH:0]                          s2;
    logic [NUM_CH:0]                          s3;
    logic [NUM_CH:0]                          lvl;
    logic [NUM_CH:0][1:0]                     nc;
    logic [pwt_pkg::PRE_W-1:0]                pres;
    logic [XW-1:0]                            cnt;
    pwt_pkg::pwt_dir_t                        dir;
    logic [pwt_pkg::CNT_W-1:0]                per_buf;
    logic [pwt_pkg::CNT_W-1:0]                per_act;
    logic [pwt_pkg::CNT_W-1:0]                cnt_buf;
    logic                                     cnt_ld;
    logic [NUM_CH-1:0][XW-1:0]                cmp_buf;
    logic [NUM_CH-1:0][XW-1:0]                cmp_act;
    logic [NUM_CH-1:0][pwt_pkg::CNT_W-1:0]    cap;
    logic [NUM_CH-1:0]                        full;
    logic [pwt_pkg::DT_W-1:0]                 dtl_buf;
    logic [pwt_pkg::DT_W-1:0]                 dth_buf;
    logic [pwt_pkg::DT_W-1:0]                 dtl;
    logic [pwt_pkg::DT_W-1:0]                 dth;
    logic [pwt_pkg::PIN_W-1:0]                pat_buf;
    logic [pwt_pkg::PIN_W-1:0]                pat_act;
    logic [NUM_CH-1:0]                        wg;
    logic                                     ovf;
    logic                                     err;
    logic [NUM_CH-1:0]                        ccev;
    logic [NUM_CH-1:0]                        dma;
    logic                                     flt;
    logic [pwt_pkg::PIN_W-1:0]                pin;
  } pwt_st_t;

  pwt_st_t                     q_ff;
  pwt_st_t                     nxt_q;
  logic [NUM_CH:0]             pin_rise;
  logic [NUM_CH:0]             pin_fall;
  logic                        src;
  logic                        tick;
  logic                        wrap;
  logic                        upd;
  logic                        restart;
  logic                        take;
  logic                        match;
  logic                        trg_r;
  logic                        awx_on;
  logic [pwt_pkg::PRE_W-1:0]   lim;
  logic [pwt_pkg::CNT_W-1:0]   top;
  logic [XW-1:0]               tope;
  logic [XW-1:0]               step;
  logic [XW-1:0]               dstep;
  logic [NUM_CH-1:0][XW-1:0]   cmpe;
  logic [pwt_pkg::PIN_W-1:0]   awx;
  logic [pwt_pkg::NUM_DTI-1:0] dls;
  logic [pwt_pkg::NUM_DTI-1:0] dhs;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.ovf  = 1'b0;
    nxt_q.err  = 1'b0;
    nxt_q.ccev = '0;
    restart    = 1'b0;
    take       = 1'b0;
    match      = 1'b0;
    trg_r      = 1'b0;
    wrap       = 1'b0;
    cmpe       = '0;
    awx        = '0;

    // Three-stage pin synchronisers; a change counts once stages two and three agree
    nxt_q.s1 = {cnt_pin, cap_pin};
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    // Capture pins also need a run of agreeing samples to reject glitches
    for (int i = 0; i <= NUM_CH; i++) begin
      if (q_ff.s2[i] == q_ff.s3[i] && q_ff.s3[i] != q_ff.lvl[i]) begin
        if (i == NUM_CH || q_ff.nc[i] == pwt_pkg::NC_LAST) begin
          nxt_q.lvl[i] = q_ff.s3[i];                                 // [R7]
          nxt_q.nc[i]  = 2'h0;
        end else begin
          nxt_q.nc[i]  = q_ff.nc[i] + 2'h1;
        end
      end else begin
        nxt_q.nc[i] = 2'h0;
      end
    end
    pin_rise = nxt_q.lvl & ~q_ff.lvl;
    pin_fall = ~nxt_q.lvl & q_ff.lvl;

    // Count source and power-of-two prescaler
    case (clk_src)                                                   // [R1]
      pwt_pkg::SRC_SYS: src = 1'b1;
      pwt_pkg::SRC_EVT: src = cnt_evt;
      pwt_pkg::SRC_PIN: src = pin_rise[NUM_CH];
      default:          src = 1'b0;
    endcase
    lim  = ~(pwt_pkg::PRE_ONES << presc_log);
    tick = src && (q_ff.pres >= lim);  // A cut in the ratio must not stall for 1024 cycles
    if (src) begin
      nxt_q.pres = tick ? '0 : q_ff.pres + 10'h001;
    end

    // Fraction bits sit below the 16-bit count; step 4 keeps them zero
    step  = resolution_extension ? pwt_pkg::STEP_HR : pwt_pkg::STEP_STD;    // [R6]
    top   = (wave_mode == pwt_pkg::WM_FRQ) ? q_ff.cmp_act[0][XW-1:2] : q_ff.per_act;
    tope  = {top, resolution_extension ? 2'b11 : 2'b00};
    dstep = (q_ff.cnt < step) ? q_ff.cnt : step;

    // Counter sequencing per waveform mode
    if (tick) begin
      if (wave_mode == pwt_pkg::WM_DS) begin
        case (q_ff.dir)
          pwt_pkg::PWT_UP: begin
            if (q_ff.cnt >= tope) begin                              // [R21]
              nxt_q.dir = pwt_pkg::PWT_DN;
              nxt_q.cnt = q_ff.cnt - dstep;
            end else begin
              nxt_q.cnt = q_ff.cnt + step;
            end
          end
          pwt_pkg::PWT_DN: begin
            if (q_ff.cnt == '0) begin                                // [R21]
              nxt_q.dir = pwt_pkg::PWT_UP;
              nxt_q.cnt = step;
              wrap      = 1'b1;
            end else begin
              nxt_q.cnt = q_ff.cnt - dstep;
            end
          end
          default: nxt_q.dir = pwt_pkg::PWT_UP;
        endcase
      end else if (wave_mode == pwt_pkg::WM_NORM && dir_dn) begin
        // Event counter running down wraps from zero to the period
        if (q_ff.cnt == '0) begin                                    // [R9]
          nxt_q.cnt = tope;
          wrap      = 1'b1;
        end else begin
          nxt_q.cnt = q_ff.cnt - dstep;
        end
      end else begin
        nxt_q.dir = pwt_pkg::PWT_UP;
        if (q_ff.cnt >= tope) begin                                  // [R21]
          nxt_q.cnt = '0;
          wrap      = 1'b1;
        end else begin
          nxt_q.cnt = q_ff.cnt + step;
        end
      end
    end

    // Buffered settings move to the active copy only at an update point
    upd = wrap || (clk_src == pwt_pkg::SRC_OFF);
    if (upd) begin
      nxt_q.per_act = q_ff.per_buf;                                  // [R3]
      nxt_q.cmp_act = q_ff.cmp_buf;                                  // [R2]
      nxt_q.dtl     = q_ff.dtl_buf;                                  // [R15]
      nxt_q.dth     = q_ff.dth_buf;
      nxt_q.pat_act = q_ff.pat_buf;                                  // [R17]
      if (q_ff.cnt_ld) begin
        nxt_q.cnt    = {q_ff.cnt_buf, 2'b00};                        // [R2]
        nxt_q.cnt_ld = 1'b0;
      end
    end
    // Writes after the update so a write in an update cycle is kept
    if (per_wr) nxt_q.per_buf = per_wdata;
    if (cnt_wr) begin
      nxt_q.cnt_buf = cnt_wdata;
      nxt_q.cnt_ld  = 1'b1;
    end
    if (dt_wr) begin
      nxt_q.dtl_buf = dt_low_wdata;
      nxt_q.dth_buf = dt_high_wdata;
    end
    if (pat_wr) nxt_q.pat_buf = pat_wdata;
    nxt_q.ovf = wrap;                                                // [R10]

    // Combined compare/capture channels
    for (int i = 0; i < NUM_CH; i++) begin
      cmpe[i] = resolution_extension ? q_ff.cmp_act[i] : {q_ff.cmp_act[i][XW-1:2], 2'b00};
      if (cmp_wr[i]) nxt_q.cmp_buf[i] = {cmp_wdata, cmp_hr_wdata};
      if (cap_en[i] && cap_mode != pwt_pkg::CAP_OFF) begin
        trg_r = cap_use_evt ? cap_evt[i] : pin_rise[i];              // [R7]
        take  = (cap_mode == pwt_pkg::CAP_PW) ? (~cap_use_evt & pin_fall[i]) : trg_r;
        if (take) begin
          nxt_q.cap[i]  = q_ff.cnt[XW-1:2];                          // [R8]
          nxt_q.ccev[i] = 1'b1;                                      // [R11]
          if (q_ff.full[i]) nxt_q.err = 1'b1;                        // [R10]
        end
        // New capture wins over a read in the same cycle
        nxt_q.full[i] = take | (q_ff.full[i] & ~cap_rd[i]);
        nxt_q.dma[i]  = nxt_q.full[i];                               // [R11]
        nxt_q.wg[i]   = 1'b0;
        if (i == 0 && trg_r && cap_mode != pwt_pkg::CAP_EDG) restart = 1'b1;  // [R8]
      end else begin
        match = tick && (q_ff.cnt == cmpe[i]);                       // [R22]
        nxt_q.ccev[i] = match;                                       // [R11]
        nxt_q.full[i] = 1'b0;
        if (wave_mode == pwt_pkg::WM_FRQ) begin
          if (match) nxt_q.wg[i] = ~q_ff.wg[i];                      // [R5]
        end else begin
          nxt_q.wg[i] = q_ff.cnt < cmpe[i];                          // [R5] [R22]
        end
        // Request a fresh compare value once the buffer has been consumed
        nxt_q.dma[i] = upd | (q_ff.dma[i] & ~cmp_wr[i]);             // [R11]
      end
    end
    // Frequency and pulse-width capture time from the rising edge
    if (restart) begin
      nxt_q.cnt = '0;                                                // [R8]
      nxt_q.dir = pwt_pkg::PWT_UP;
    end

    // Fault is sticky; a new fault wins over a clear
    nxt_q.flt = (|(sys_evt & flt_sel)) | (q_ff.flt & ~flt_clr);      // [R19]

    // Extension output mux
    awx_on = (NUM_CH == pwt_pkg::NUM_DTI) && (dti_en || pgen_en || spread_a_en);  // [R4] [R12]
    for (int k = 0; k < pwt_pkg::NUM_DTI; k++) begin
      awx[2*k]   = dls[k];                                           // [R14]
      awx[2*k+1] = dhs[k];
    end
    if (pgen_en) awx = q_ff.pat_act;                                 // [R17]
    if (awx_on && !q_ff.flt) begin
      nxt_q.pin = (ovr_en & awx) | (~ovr_en & port_val);             // [R16] [R19]
    end else begin
      nxt_q.pin = port_val;
    end
    nxt_q.pin = nxt_q.pin ^ pin_invert_enable;                       // [R20]
  end

  // Dead-time units exist only on the four-channel variant
  genvar g;
  generate
    for (g = 0; g < pwt_pkg::NUM_DTI; g++) begin : g_dti
      if (NUM_CH == pwt_pkg::NUM_DTI) begin : g_on
        pwt_dti u_dti (
          .clock            (clock),
          .rst_n            (rst_n),
          .wave_in          (spread_a_en ? q_ff.wg[0] : q_ff.wg[g]), // [R18]
          .dt_low           (dti_en ? q_ff.dtl : pwt_pkg::DT_RST),
          .dt_high          (dti_en ? q_ff.dth : pwt_pkg::DT_RST),
          .low_side_output  (dls[g]),
          .high_side_output (dhs[g])
        );
      end else begin : g_off
        assign dls[g] = 1'b0;                                        // [R4]
        assign dhs[g] = 1'b0;
      end
    end
  endgenerate

  // Single state register; direction resets to counting up
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q_ff     <= '0;
      q_ff.dir <= pwt_pkg::PWT_UP;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from the state register
  assign cnt_val         = q_ff.cnt[XW-1:2];
  assign waveform_output = q_ff.wg;
  assign cc_val          = q_ff.cap;
  assign ovf_evt         = q_ff.ovf;
  assign err_evt         = q_ff.err;
  assign cc_evt          = q_ff.ccev;
  assign dma_req         = q_ff.dma;
  assign flt_active      = q_ff.flt;
  assign pin_out         = q_ff.pin;
endmodule // pwt_timer

/* File: tb/pwt_timer_sva.sv */
// Assertion checker for the PWM timer top: fault path, pins and capture.
// Assumes it is bound into the timer and the pins use the four-leg layout.
`timescale 1ns/10ps
module pwt_timer_sva #(
  parameter int NUM_CH = 4
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              cap_use_evt,
  input wire logic [1:0]        cap_mode,
  input wire logic [NUM_CH-1:0] cap_en,
  input wire logic [NUM_CH-1:0] cap_evt,
  input wire logic [NUM_CH-1:0] cap_rd,
  input wire logic [NUM_CH-1:0] cc_evt,
  input wire logic [NUM_CH-1:0] dma_req,
  input wire logic              err_evt,
  input wire logic              dti_en,
  input wire logic              pgen_en,
  input wire logic              spread_a_en,
  input wire logic [7:0]        ovr_en,
  input wire logic [7:0]        pin_invert_enable,
  input wire logic [7:0]        port_val,
  input wire logic [7:0]        sys_evt,
  input wire logic [7:0]        flt_sel,
  input wire logic              flt_clr,
  input wire logic              flt_active,
  input wire logic [7:0]        pin_out
);
  // Fault trigger, plain port path and an armed channel 0 event capture
  wire logic flt_hit = |(sys_evt & flt_sel);
  wire logic ext_off = !dti_en && !pgen_en && !spread_a_en;
  wire logic cap_arm = cap_en[0] && cap_use_evt && cap_mode == pwt_pkg::CAP_EDG && cap_evt[0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_fault_sets: assert property (flt_hit |=> flt_active)
    else $error("fault flag not raised");
  a_fault_holds: assert property (flt_active && !flt_clr |=> flt_active)
    else $error("fault flag dropped");
  a_fault_clears: assert property (flt_active && flt_clr && !flt_hit |=> !flt_active)
    else $error("fault flag not cleared");
  a_fault_pins_safe: assert property (
    flt_active |=> pin_out == $past(port_val ^ pin_invert_enable))
    else $error("pins not safe in fault");
  a_plain_port_path: assert property (
    ext_off |=> pin_out == $past(port_val ^ pin_invert_enable))
    else $error("plain pin value wrong");
  a_capture_takes: assert property (
    cap_arm && !dma_req[0] && !cap_rd[0] |=> cc_evt[0] && dma_req[0])
    else $error("capture not flagged");
  a_capture_overrun: assert property (cap_arm && dma_req[0] && !cap_rd[0] |=> err_evt)
    else $error("overrun without error");
  a_dead_gap_kept: assert property (
    dti_en && !pgen_en && !spread_a_en && &ovr_en && pin_invert_enable == 8'h00 && !flt_active
    |=> (pin_out & (pin_out >> 1) & 8'h55) == 8'h00)
    else $error("both sides of a leg on");
endmodule // pwt_timer_sva

/* File: tb/pwt_bridge_model.sv */
// Four half-bridge power stages hanging on the eight output pins.
// Assumes pin 2k drives the low switch and pin 2k+1 the high switch of leg k.
`timescale 1ns/10ps
module pwt_bridge_model (
  input  wire logic       clock,
  input  wire logic       armed,
  input  wire logic [7:0] pin_out,
  output logic      [7:0] shoot_cnt
);
  // Both switches of one leg on shorts the supply, so every such cycle while armed is counted
  initial shoot_cnt = 8'h00;
  always @(posedge clock) begin
    if (armed && (pin_out & (pin_out >> 1) & 8'h55) != 8'h00) begin
      shoot_cnt <= shoot_cnt + 8'h01;
    end
  end
endmodule // pwt_bridge_model

/* File: tb/tb_top.sv */
// Self-checking bench for the PWM timer with dead-time extension.
// Assumes the four-channel variant, a 50 MHz clock and a bridge model on the pins.
`timescale 1ns/10ps
module tb_top;
  logic        clock, rst_n, resolution_extension, dir_dn, cnt_evt, cnt_pin, per_wr, cnt_wr;
  logic        cap_use_evt, dti_en, dt_wr, pgen_en, pat_wr, spread_a_en, flt_clr;
  logic        ovf_evt, err_evt, flt_active;
  logic [1:0]  clk_src, wave_mode, cap_mode, cmp_hr_wdata;
  logic [3:0]  presc_log, cmp_wr, cap_en, cap_evt, cap_pin, cap_rd;
  logic [3:0]  waveform_output, cc_evt, dma_req;
  logic [7:0]  dt_low_wdata, dt_high_wdata, pat_wdata, ovr_en, pin_invert_enable;
  logic [7:0]  port_val, sys_evt, flt_sel, pin_out, shoot_cnt;
  logic [15:0] per_wdata, cnt_wdata, cmp_wdata, cnt_val, lfsr;
  logic [63:0] cc_val;
  int          errors, n_checks, cyc, last_ovf;
  int          q_ovf[$];
  logic [15:0] q_cap[$];

  pwt_timer #(.NUM_CH(4)) DUT (.*);
  pwt_bridge_model u_bridge (.clock(clock), .armed(dti_en & ~pgen_en), .pin_out(pin_out),
                             .shoot_cnt(shoot_cnt));

  // 50 MHz clock and a cycle count for gap measurement
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Inputs always move 2 ns after the rising edge, clear of the sampling point
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  task automatic wait_ovf();
    for (int i = 0; ovf_evt !== 1'b1; i++) begin
      if (i == 400) begin
        check(16'h0000, 16'h0001, "overflow timeout");
        finish_test();
      end
      step(1);
    end
    step(1);
  endtask

  // Freeze the count to load period and zero, then run and note two gaps
  task automatic run_mode(input logic [1:0] m, input logic [3:0] p, input logic [15:0] per,
                          input int gap);
    {wave_mode, presc_log, per_wdata, clk_src} = {m, p, per, pwt_pkg::SRC_OFF};
    {per_wr, cnt_wr} = 2'b11;
    step(2);
    {per_wr, cnt_wr, clk_src} = {2'b00, pwt_pkg::SRC_SYS};
    repeat (2) wait_ovf();
    q_ovf = '{gap, gap};
    repeat (2) wait_ovf();
    $display("test counter mode %0d done", m);
  endtask

  // Watcher: each overflow gap or channel 0 capture takes the oldest note
  always @(negedge clock) begin
    if (ovf_evt === 1'b1) begin
      if (q_ovf.size() > 0) check(16'(cyc - last_ovf), 16'(q_ovf.pop_front()), "gap");
      last_ovf = cyc;
    end
    if (cc_evt[0] === 1'b1 && q_cap.size() > 0) check(cc_val[15:0], q_cap.pop_front(), "cap");
  end

  // Main sequence: reset, plain pins, counter, dead time and fault, spread, capture
  initial begin
    {rst_n, resolution_extension, dir_dn, cnt_evt, cnt_pin, per_wr, cnt_wr, cap_use_evt,
     dti_en, dt_wr, pgen_en, pat_wr, spread_a_en, flt_clr, clk_src, wave_mode, cap_mode,
     cmp_hr_wdata, presc_log, cmp_wr, cap_en, cap_evt, cap_pin, cap_rd, dt_low_wdata,
     dt_high_wdata, pat_wdata, ovr_en, sys_evt, flt_sel, per_wdata, cnt_wdata, cmp_wdata} = '0;
    lfsr = 16'h0041;
    {port_val, pin_invert_enable} = 16'h3c0f;
    repeat (6) @(posedge clock);
    #2 rst_n = 1'b1;
    step(1);
    check(16'(pin_out), 16'h0033, "pins after reset");
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      {port_val, pin_invert_enable} = lfsr;
      step(1);
      check(16'(pin_out), 16'(port_val ^ pin_invert_enable), "plain pins");
    end
    $display("test pins done");
    run_mode(pwt_pkg::WM_SS, 4'h1, 16'h0009, 20);
    dir_dn = 1'b1;
    run_mode(pwt_pkg::WM_NORM, 4'h0, 16'h0009, 10);
    dir_dn = 1'b0;
    run_mode(pwt_pkg::WM_DS, 4'h0, 16'h0004, 8);
    resolution_extension = 1'b1;
    run_mode(pwt_pkg::WM_SS, 4'h0, 16'h0002, 12);
    resolution_extension = 1'b0;
    run_mode(pwt_pkg::WM_SS, 4'h0, 16'h0009, 10);
    // A period written mid-cycle must wait for the wrap
    q_ovf = '{10, 5};
    per_wdata = 16'h0004;
    per_wr = 1'b1;
    step(1);
    per_wr = 1'b0;
    repeat (2) wait_ovf();
    $display("test period buffer done");
    {ovr_en, pin_invert_enable, port_val, flt_sel} = 32'hff00_2108;
    {dt_low_wdata, dt_high_wdata, cmp_wdata} = 32'h0302_0002;
    {dti_en, dt_wr, cmp_wr} = 6'h3f;
    step(1);
    {dt_wr, cmp_wr} = 5'h00;
    step(40);
    sys_evt = 8'h04;
    step(1);
    check(16'(flt_active), 16'h0000, "unselected event");
    sys_evt = 8'h08;
    step(1);
    sys_evt = 8'h00;
    step(1);
    check({7'h00, flt_active, pin_out}, 16'h0121, "fault pins");
    flt_clr = 1'b1;
    step(1);
    flt_clr = 1'b0;
    check(16'(flt_active), 16'h0000, "fault cleared");
    $display("test dead time and fault done");
    {spread_a_en, dti_en} = 2'b10;
    for (int i = 0; i < 2; i++) begin
      cmp_wdata = i ? 16'hffff : 16'h0000;
      cmp_wr = 4'h1;
      step(1);
      cmp_wr = 4'h0;
      step(20);
      check(16'(waveform_output[0]), 16'(i), "wave a");
      check(16'(pin_out), i ? 16'h0055 : 16'h00aa, "spread pins");
    end
    $display("test spread done");
    {spread_a_en, clk_src, cap_en, cap_use_evt, cap_mode} =
      {1'b0, pwt_pkg::SRC_OFF, 4'h1, 1'b1, pwt_pkg::CAP_EDG};
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      cnt_wdata = lfsr;
      cnt_wr = 1'b1;
      step(1);
      cnt_wr = 1'b0;
      step(2);
      check(cnt_val, lfsr, "count load");
      q_cap.push_back(lfsr);
      cap_evt = 4'h1;
      step(1);
      cap_evt = {3'h0, i == 3};
      step(1);
      check(16'(err_evt), 16'(i == 3), "overrun");
      cap_evt = 4'h0;
      check(16'(dma_req[0]), 16'h0001, "capture full");
      cap_rd = 4'h1;
      step(1);
      cap_rd = 4'h0;
      step(1);
      check(16'(dma_req[0]), 16'h0000, "read clears");
    end
    $display("test capture done");
    check(16'(shoot_cnt), 16'h0000, "bridge overlap");
    check(16'(q_ovf.size() + q_cap.size()), 16'h0000, "pending notes");
    finish_test();
  end
endmodule // tb_top

bind pwt_timer pwt_timer_sva #(.NUM_CH(NUM_CH)) u_sva (.*);
